// ===== src/color_proc_pkg.sv
package color_proc_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_MODE_SEL     = 8'h01;
   localparam logic [7:0] ADDR_OUT_CTRL     = 8'h02;
   localparam logic [7:0] ADDR_GY_LOW       = 8'h03;
   localparam logic [7:0] ADDR_SHARED_LOW   = 8'h04;
   localparam logic [7:0] ADDR_GY_HIGH      = 8'h05;
   localparam logic [7:0] ADDR_GU_HIGH      = 8'h06;
   localparam logic [7:0] ADDR_GV_HIGH      = 8'h07;
   localparam logic [7:0] ADDR_BU_HIGH      = 8'h08;
   localparam logic [7:0] ADDR_RV_HIGH      = 8'h09;
   localparam logic [7:0] ADDR_HD_STD       = 8'h30;
   localparam logic [7:0] ADDR_HD_PATTERN   = 8'h31;
   localparam logic [7:0] ADDR_HD_IN_CTRL   = 8'h35;
   localparam logic [7:0] ADDR_PAT_FIRST    = 8'h36;
   localparam logic [7:0] ADDR_PAT_SECOND   = 8'h37;
   localparam logic [7:0] ADDR_PAT_THIRD    = 8'h38;
   localparam logic [7:0] ADDR_SD_STD       = 8'h80;
   localparam logic [7:0] ADDR_SD_CTRL      = 8'h87;
   localparam logic [7:0] ADDR_SCALE_LOW    = 8'h9c;
   localparam logic [7:0] ADDR_LUMA_SCALE   = 8'h9d;
   localparam logic [7:0] ADDR_CB_SCALE     = 8'h9e;
   localparam logic [7:0] ADDR_CR_SCALE     = 8'h9f;
   localparam logic [7:0] ADDR_HUE          = 8'ha0;
   // Bit positions
   localparam int BIT_RGB_SYNC      = 4;
   localparam int BIT_YPRPB_OUT     = 5;
   localparam int BIT_MANUAL_CSC    = 3;
   localparam int BIT_PATTERN_EN    = 2;
   localparam int BIT_HD_RGB_IN     = 1;
   localparam int BIT_SYNC_PRPB     = 2;
   localparam int BIT_SD_RGB_IN     = 7;
   localparam int BIT_HUE_EN        = 2;
   localparam int MODE_LSB          = 4;
   localparam logic [2:0] MODE_SD   = 3'h0;
   localparam logic [1:0] SD_STD_PAL = 2'h1;
   // Reset values
   localparam logic [7:0] RST_GY_LOW     = 8'h03;
   localparam logic [7:0] RST_SHARED_LOW = 8'hf0;
   localparam logic [7:0] RST_GY_HIGH    = 8'h4e;
   localparam logic [7:0] RST_GU_HIGH    = 8'h0e;
   localparam logic [7:0] RST_GV_HIGH    = 8'h24;
   localparam logic [7:0] RST_BU_HIGH    = 8'h92;
   localparam logic [7:0] RST_RV_HIGH    = 8'h7c;
   localparam logic [7:0] RST_PAT_LUMA   = 8'h10;
   localparam logic [7:0] RST_PAT_CHROMA = 8'h80;
   localparam logic [7:0] RST_SCALE_HIGH = 8'h80;
   localparam logic [7:0] RST_HUE        = 8'h80;
   // Arithmetic: coefficients are real value times 315
   localparam logic [9:0]  UNITY_SCALE  = 10'h200;
   localparam int          SCALE_SHIFT  = 9;
   localparam logic [7:0]  CHROMA_ZERO  = 8'h80;
   localparam logic [7:0]  HUE_CENTER   = 8'h80;
   localparam logic [7:0]  HUE_PAL_MIN  = 8'h01;
   localparam logic [15:0] RECIP_315    = 16'h3404;
   localparam int          RECIP_SHIFT  = 22;
   // Automatic ED/HD coefficients (HD colorimetry)
   localparam logic [9:0] HD_GY = 10'h13b;
   localparam logic [9:0] HD_GU = 10'h03b;
   localparam logic [9:0] HD_GV = 10'h093;
   localparam logic [9:0] HD_BU = 10'h248;
   localparam logic [9:0] HD_RV = 10'h1f0;
   // Automatic SD coefficients (BT.601)
   localparam logic [9:0] SD_RV = 10'h1ba;
   localparam logic [9:0] SD_GV = 10'h0e1;
   localparam logic [9:0] SD_GU = 10'h06c;
   localparam logic [9:0] SD_BU = 10'h22e;
   localparam logic [9:0] SD_KR = 10'h05e;
   localparam logic [9:0] SD_KG = 10'h0b9;
   localparam logic [9:0] SD_KB = 10'h024;
   localparam logic [9:0] SD_KCB = 10'h0b2;
   localparam logic [9:0] SD_KCR = 10'h0e1;

   typedef struct packed {
      logic       valid;
      logic [7:0] c0;     // Y or G
      logic [7:0] c1;     // Cb/Pb or B
      logic [7:0] c2;     // Cr/Pr or R
   } pixel_t;
endpackage : color_proc_pkg

// ===== src/video_color_processing.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module video_color_processing
   import color_proc_pkg::*;
(
   input  wire logic              ref_clk,     // Pixel clock
   input  wire logic              rst_n,       // Asynchronous reset
   input  wire logic [7:0]        reg_addr,    // Register address
   input  wire logic [7:0]        reg_wdata,   // Write data
   input  wire logic              reg_wr,      // Write strobe
   input  wire logic              reg_rd,      // Read strobe
   output logic      [7:0]        reg_rdata,   // Read data, cycle after strobe
   input  wire pixel_t            pix_in,      // Pixel from video source
   output pixel_t                 pix_out,     // Component output pixel
   output pixel_t                 comp_out,    // Composite / luma-chroma pixel
   output logic signed [8:0]      hue_offset,  // Chroma phase offset, 0.17578125 deg steps
   output logic                   sync_rgb,    // Sync on RGB enable
   output logic                   sync_prpb    // Sync on PrPb enable
);
   logic [7:0] mode_reg, out_ctrl_reg, hd_std_reg, hd_pat_reg, hd_in_reg;
   logic [7:0] sd_std_reg, sd_ctrl_reg;
   logic [7:0] gy_low_reg, shared_low_reg, gy_hi_reg, gu_hi_reg, gv_hi_reg;
   logic [7:0] bu_hi_reg, rv_hi_reg;
   logic [7:0] pat0_reg, pat1_reg, pat2_reg;
   logic [7:0] scale_low_reg, y_scale_reg, cb_scale_reg, cr_scale_reg, hue_reg;
   logic [7:0] rd_next;
   pixel_t     in_reg, sd_ycc_reg, out_next;

   wire sd_mode    = mode_reg[MODE_LSB +: 3] == MODE_SD;
   wire ypbpr_out  = out_ctrl_reg[BIT_YPRPB_OUT];
   wire manual_en  = out_ctrl_reg[BIT_MANUAL_CSC];
   wire pattern_en = hd_pat_reg[BIT_PATTERN_EN];
   wire hd_rgb_in  = hd_in_reg[BIT_HD_RGB_IN];
   wire sd_rgb_in  = sd_ctrl_reg[BIT_SD_RGB_IN];
   wire hue_en     = sd_ctrl_reg[BIT_HUE_EN];

   // Register file
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg       <= '0;
         out_ctrl_reg   <= '0;
         hd_std_reg     <= '0;
         hd_pat_reg     <= '0;
         hd_in_reg      <= '0;
         sd_std_reg     <= '0;
         sd_ctrl_reg    <= '0;
         gy_low_reg     <= RST_GY_LOW;
         shared_low_reg <= RST_SHARED_LOW;
         gy_hi_reg      <= RST_GY_HIGH;
         gu_hi_reg      <= RST_GU_HIGH;
         gv_hi_reg      <= RST_GV_HIGH;
         bu_hi_reg      <= RST_BU_HIGH;
         rv_hi_reg      <= RST_RV_HIGH;
         pat0_reg       <= RST_PAT_LUMA;
         pat1_reg       <= RST_PAT_CHROMA;
         pat2_reg       <= RST_PAT_CHROMA;
         scale_low_reg  <= '0;
         y_scale_reg    <= RST_SCALE_HIGH;
         cb_scale_reg   <= RST_SCALE_HIGH;
         cr_scale_reg   <= RST_SCALE_HIGH;
         hue_reg        <= RST_HUE;
      end else if (reg_wr) begin
         unique case (reg_addr)
            ADDR_MODE_SEL:   mode_reg       <= reg_wdata;
            ADDR_OUT_CTRL:   out_ctrl_reg   <= reg_wdata;
            ADDR_HD_STD:     hd_std_reg     <= reg_wdata;
            ADDR_HD_PATTERN: hd_pat_reg     <= reg_wdata;
            ADDR_HD_IN_CTRL: hd_in_reg      <= reg_wdata;
            ADDR_SD_STD:     sd_std_reg     <= reg_wdata;
            ADDR_SD_CTRL:    sd_ctrl_reg    <= reg_wdata;
            ADDR_GY_LOW:     gy_low_reg     <= reg_wdata;
            ADDR_SHARED_LOW: shared_low_reg <= reg_wdata;
            ADDR_GY_HIGH:    gy_hi_reg      <= reg_wdata;
            ADDR_GU_HIGH:    gu_hi_reg      <= reg_wdata;
            ADDR_GV_HIGH:    gv_hi_reg      <= reg_wdata;
            ADDR_BU_HIGH:    bu_hi_reg      <= reg_wdata;
            ADDR_RV_HIGH:    rv_hi_reg      <= reg_wdata;
            ADDR_PAT_FIRST:  pat0_reg       <= reg_wdata;
            ADDR_PAT_SECOND: pat1_reg       <= reg_wdata;
            ADDR_PAT_THIRD:  pat2_reg       <= reg_wdata;
            ADDR_SCALE_LOW:  scale_low_reg  <= reg_wdata;
            ADDR_LUMA_SCALE: y_scale_reg    <= reg_wdata;
            ADDR_CB_SCALE:   cb_scale_reg   <= reg_wdata;
            ADDR_CR_SCALE:   cr_scale_reg   <= reg_wdata;
            ADDR_HUE:        hue_reg        <= reg_wdata;
            default: ;
         endcase
      end
   end

   always_comb begin
      unique case (reg_addr)
         ADDR_MODE_SEL:   rd_next = mode_reg;
         ADDR_OUT_CTRL:   rd_next = out_ctrl_reg;
         ADDR_HD_STD:     rd_next = hd_std_reg;
         ADDR_HD_PATTERN: rd_next = hd_pat_reg;
         ADDR_HD_IN_CTRL: rd_next = hd_in_reg;
         ADDR_SD_STD:     rd_next = sd_std_reg;
         ADDR_SD_CTRL:    rd_next = sd_ctrl_reg;
         ADDR_GY_LOW:     rd_next = gy_low_reg;
         ADDR_SHARED_LOW: rd_next = shared_low_reg;
         ADDR_GY_HIGH:    rd_next = gy_hi_reg;
         ADDR_GU_HIGH:    rd_next = gu_hi_reg;
         ADDR_GV_HIGH:    rd_next = gv_hi_reg;
         ADDR_BU_HIGH:    rd_next = bu_hi_reg;
         ADDR_RV_HIGH:    rd_next = rv_hi_reg;
         ADDR_PAT_FIRST:  rd_next = pat0_reg;
         ADDR_PAT_SECOND: rd_next = pat1_reg;
         ADDR_PAT_THIRD:  rd_next = pat2_reg;
         ADDR_SCALE_LOW:  rd_next = scale_low_reg;
         ADDR_LUMA_SCALE: rd_next = y_scale_reg;
         ADDR_CB_SCALE:   rd_next = cb_scale_reg;
         ADDR_CR_SCALE:   rd_next = cr_scale_reg;
         ADDR_HUE:        rd_next = hue_reg;
         default:         rd_next = '0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) reg_rdata <= '0;
      else if (reg_rd) reg_rdata <= rd_next;
      else reg_rdata <= '0;
   end

   // Coefficients: high byte carries bits 9:2
   wire [9:0] gy_c = manual_en ? {gy_hi_reg, gy_low_reg[1:0]} : HD_GY;
   wire [9:0] gu_c = manual_en ? {gu_hi_reg, shared_low_reg[7:6]} : HD_GU;
   wire [9:0] gv_c = manual_en ? {gv_hi_reg, shared_low_reg[5:4]} : HD_GV;
   wire [9:0] bu_c = manual_en ? {bu_hi_reg, shared_low_reg[3:2]} : HD_BU;
   wire [9:0] rv_c = manual_en ? {rv_hi_reg, shared_low_reg[1:0]} : HD_RV;
   wire [9:0] y_sc  = {y_scale_reg,  scale_low_reg[1:0]};
   wire [9:0] cb_sc = {cb_scale_reg, scale_low_reg[3:2]};
   wire [9:0] cr_sc = {cr_scale_reg, scale_low_reg[5:4]};

   // Coefficient times sample, coefficient unsigned
   function automatic logic signed [39:0] mul(input logic [9:0] k,
                                             input logic signed [39:0] v);
      mul = $signed({30'h0, k}) * v;
   endfunction : mul

   // Divide by 315 via reciprocal; avoids a real divider in the pixel path
   function automatic logic signed [39:0] div315(input logic signed [39:0] v);
      div315 = (v * $signed({24'h0, RECIP_315})) >>> RECIP_SHIFT;
   endfunction : div315

   function automatic logic [7:0] sat8(input logic signed [39:0] v);
      if (v < 0) sat8 = '0;
      else if (v > 40'sd255) sat8 = 8'hff;
      else sat8 = v[7:0];
   endfunction : sat8

   function automatic logic signed [39:0] ext(input logic [7:0] v);
      ext = $signed({32'h0, v});
   endfunction : ext

   // Stage 1: SD input to YCbCr, then level scaling
   logic signed [39:0] s_y, s_cb, s_cr, s_r, s_g, s_b;
   pixel_t             sd_ycc_next;
   always_comb begin
      s_g = ext(pix_in.c0);
      s_b = ext(pix_in.c1);
      s_r = ext(pix_in.c2);
      if (sd_rgb_in) begin
         s_y  = div315(mul(SD_KR, s_r) + mul(SD_KG, s_g) + mul(SD_KB, s_b));
         s_cb = div315(mul(SD_KCB, s_b - s_y));
         s_cr = div315(mul(SD_KCR, s_r - s_y));
      end else begin
         s_y  = s_g;
         s_cb = s_b - ext(CHROMA_ZERO);
         s_cr = s_r - ext(CHROMA_ZERO);
      end
      sd_ycc_next.valid = pix_in.valid;
      sd_ycc_next.c0 = sat8(mul(y_sc, s_y) >>> SCALE_SHIFT);
      sd_ycc_next.c1 = sat8((mul(cb_sc, s_cb) >>> SCALE_SHIFT) + ext(CHROMA_ZERO));
      sd_ycc_next.c2 = sat8((mul(cr_sc, s_cr) >>> SCALE_SHIFT) + ext(CHROMA_ZERO));
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_reg     <= '0;
         sd_ycc_reg <= '0;
      end else begin
         in_reg     <= pix_in;
         sd_ycc_reg <= sd_ycc_next;
      end
   end

   // Stage 2: output color space
   logic signed [39:0] e_y, e_pb, e_pr, t_y, q_y, q_pb, q_pr;
   always_comb begin
      e_y  = ext(in_reg.c0);
      e_pb = ext(in_reg.c1) - ext(CHROMA_ZERO);
      e_pr = ext(in_reg.c2) - ext(CHROMA_ZERO);
      t_y  = mul(gy_c, e_y);
      q_y  = ext(sd_ycc_reg.c0);
      q_pb = ext(sd_ycc_reg.c1) - ext(CHROMA_ZERO);
      q_pr = ext(sd_ycc_reg.c2) - ext(CHROMA_ZERO);
      out_next = in_reg;
      if (sd_mode) begin
         out_next = sd_ycc_reg;
         if (!ypbpr_out) begin
            out_next.c0 = sat8(q_y - div315(mul(SD_GU, q_pb) + mul(SD_GV, q_pr)));
            out_next.c1 = sat8(q_y + div315(mul(SD_BU, q_pb)));
            out_next.c2 = sat8(q_y + div315(mul(SD_RV, q_pr)));
         end
      end else if (pattern_en) begin
         // Raw color codes, matrix bypassed; 235/128/128 gives white
         out_next.c0 = pat0_reg;
         out_next.c1 = pat1_reg;
         out_next.c2 = pat2_reg;
      end else if (!hd_rgb_in) begin
         if (ypbpr_out) begin
            out_next.c0 = sat8(div315(t_y));
            out_next.c1 = sat8(div315(mul(bu_c, e_pb)) + ext(CHROMA_ZERO));
            out_next.c2 = sat8(div315(mul(rv_c, e_pr)) + ext(CHROMA_ZERO));
         end else begin
            out_next.c0 = sat8(div315(t_y - mul(gu_c, e_pb) - mul(gv_c, e_pr)));
            out_next.c1 = sat8(div315(t_y + mul(bu_c, e_pb)));
            out_next.c2 = sat8(div315(t_y + mul(rv_c, e_pr)));
         end
      end
      // In ED/HD, RGB in is passed as RGB; RGB in to YPrPb out has no conversion
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pix_out   <= '0;
         comp_out  <= '0;
         sync_rgb  <= 1'b0;
         sync_prpb <= 1'b0;
      end else begin
         pix_out   <= out_next;
         comp_out  <= sd_ycc_reg;
         sync_rgb  <= out_ctrl_reg[BIT_RGB_SYNC];
         sync_prpb <= hd_in_reg[BIT_SYNC_PRPB];
      end
   end

   // Hue: offset in 0.17578125 degree steps, driven on hue_offset whenever hue_en is set
   logic [7:0] hue_eff;
   always_comb begin
      hue_eff = hue_reg;
      if (sd_std_reg[1:0] == SD_STD_PAL && hue_reg < HUE_PAL_MIN)
         hue_eff = HUE_PAL_MIN;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) hue_offset <= '0;
      else if (hue_en)
         hue_offset <= $signed({1'b0, hue_eff}) - $signed({1'b0, HUE_CENTER});
      else hue_offset <= '0;
   end

   // Checks
   sequence s_cfg_hold(c);
      c && !reg_wr ##1 !reg_wr;
   endsequence

   a_rd_unmapped: assert property (@(posedge ref_clk) disable iff (!rst_n)
      reg_rd && reg_addr == 8'hff |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rd_scale: assert property (@(posedge ref_clk) disable iff (!rst_n)
      reg_rd && reg_addr == ADDR_LUMA_SCALE |=> reg_rdata == $past(y_scale_reg))
      else $error("luma scale readback wrong");
   a_hue_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !hue_en |=> hue_offset == 9'sd0)
      else $error("hue offset while disabled");
   a_hue_ntsc: assert property (@(posedge ref_clk) disable iff (!rst_n)
      hue_en && sd_std_reg[1:0] != SD_STD_PAL |=>
      hue_offset == $signed({1'b0, $past(hue_reg)}) - 9'sd128)
      else $error("hue offset not value minus 128");
   a_hue_pal_floor: assert property (@(posedge ref_clk) disable iff (!rst_n)
      hue_en && sd_std_reg[1:0] == SD_STD_PAL && hue_reg == 8'h00 |=>
      hue_offset == -9'sd127)
      else $error("pal hue below floor");
   a_pattern_bypass: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_cfg_hold(!sd_mode && pattern_en) |=>
      pix_out.c0 == pat0_reg && pix_out.c2 == pat2_reg)
      else $error("pattern not passed through");
   a_hd_rgb_pass: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_cfg_hold(!sd_mode && !pattern_en && hd_rgb_in) |=>
      pix_out == $past(pix_in, 2))
      else $error("rgb input altered in ed/hd");
   a_comp_valid: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pix_in.valid |-> ##2 comp_out.valid)
      else $error("composite output missing");
   a_luma_sat: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_cfg_hold(sd_mode && !sd_rgb_in && ypbpr_out && y_sc >= UNITY_SCALE
      && pix_in.c0 == 8'hff) |=> pix_out.c0 == 8'hff)
      else $error("scaled luma wrapped");
   a_unity_scale: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_cfg_hold(sd_mode && !sd_rgb_in && ypbpr_out && y_sc == UNITY_SCALE
      && cb_sc == UNITY_SCALE) |=> pix_out.c0 == $past(pix_in.c0, 2)
      && pix_out.c1 == $past(pix_in.c1, 2))
      else $error("unity scale changed level");
endmodule : video_color_processing

// ===== dv/pixel_source.sv
`timescale 1ns/1ps
module pixel_source
   import color_proc_pkg::*;
(
   input  wire logic   ref_clk, // Pixel clock
   input  wire logic   rst_n,   // Asynchronous reset
   input  wire logic   send,    // Present px_req next cycle
   input  wire pixel_t px_req,  // Pixel to present
   output pixel_t      pix_in   // Line towards the block
);
   // Idle cycles show inverted stale data, so a late sample never matches by luck
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) pix_in <= '0;
      else if (send) pix_in <= px_req;
      else pix_in <= {1'b0, ~pix_in[23:0]};
   end
endmodule : pixel_source

// ===== dv/testbench.sv
`timescale 1ns/1ps
module testbench import color_proc_pkg::*; ;
   logic              ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, send = 1'b0;
   logic [7:0]        reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, h;
   pixel_t            px_req = '0, pix_in, pix_out, comp_out, p;
   logic signed [8:0] hue_offset;
   logic              sync_rgb, sync_prpb, rd_wait = 1'b0;
   int                bad_count = 0, num_checks = 0, cyc = 0;
   logic [7:0]        rq[$], v[7];
   pixel_t            pq[$], cq[$];
   logic [7:0] ra[16] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h36,
                          8'h37, 8'h38, 8'h9c, 8'h9d, 8'h9e, 8'h9f, 8'ha0, 8'hff};
   logic [7:0] rv[16] = '{8'h03, 8'hf0, 8'h4e, 8'h0e, 8'h24, 8'h92, 8'h7c, 8'h10,
                          8'h80, 8'h80, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00};

   always #12.5 ref_clk = ~ref_clk;

   pixel_source pixel_source_i (.ref_clk(ref_clk), .rst_n(rst_n), .send(send),
                                .px_req(px_req), .pix_in(pix_in));
   video_color_processing video_color_processing_i (.ref_clk(ref_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .pix_in(pix_in), .pix_out(pix_out), .comp_out(comp_out),
      .hue_offset(hue_offset), .sync_rgb(sync_rgb), .sync_prpb(sync_prpb));

   task automatic cmp(input logic [24:0] got, input logic [24:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic cmp_px(input pixel_t got, input pixel_t exp);
      cmp(got, exp);
   endtask : cmp_px
   task automatic results;
      if (rq.size() + pq.size() + cq.size() != 0) bad_count++;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1; reg_rd <= 1'b0; reg_addr <= a; reg_wdata <= d;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1; reg_wr <= 1'b0; reg_addr <= a; rq.push_back(e);
   endtask : rd
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         reg_wr <= 1'b0; reg_rd <= 1'b0; send <= 1'b0;
      end
   endtask : idle
   // Expected results are noted on the way in and popped when an output turns valid
   task automatic px(input pixel_t d, input pixel_t ep, input pixel_t ec, input logic up,
                     input logic uc);
      @(posedge ref_clk);
      send <= 1'b1; px_req <= d; reg_wr <= 1'b0; reg_rd <= 1'b0;
      if (up) pq.push_back(ep);
      if (uc) cq.push_back(ec);
   endtask : px
   task automatic hue_chk(input logic [8:0] e);
      idle(3);
      @(negedge ref_clk);
      cmp({16'h0000, hue_offset}, {16'h0000, e});
   endtask : hue_chk

   always @(negedge ref_clk) begin
      if (rd_wait) cmp({17'h0, reg_rdata}, {17'h0, rq.pop_front()});
      rd_wait = reg_rd;
      if (pix_out.valid === 1'b1 && pq.size() > 0) cmp_px(pix_out, pq.pop_front());
      if (comp_out.valid === 1'b1 && cq.size() > 0) cmp_px(comp_out, cq.pop_front());
   end

   // Whole run is about 160 cycles; the ceiling leaves wide margin
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         results();
      end
   end

   initial begin
      void'($urandom(22));
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 16; i++) rd(ra[i], rv[i]);
      for (int i = 0; i < 7; i++) begin
         v[i] = 8'($urandom);
         wr(8'(3 + i), v[i]);
      end
      for (int i = 0; i < 7; i++) rd(8'(3 + i), v[i]);
      idle(2);
      $display("test registers done");
      wr(ADDR_SD_CTRL, 8'h04);
      for (int i = 0; i < 4; i++) begin
         h = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
         wr(ADDR_HUE, h);
         hue_chk({1'b0, h} - 9'h080);
      end
      wr(ADDR_SD_STD, 8'h01);
      wr(ADDR_HUE, 8'h00);
      hue_chk(9'h181);
      wr(ADDR_SD_CTRL, 8'h00);
      hue_chk(9'h000);
      wr(ADDR_SD_STD, 8'h00);
      idle(4);
      $display("test hue done");
      repeat (4) begin
         p = {1'b1, 24'($urandom)};
         px(p, p, p, 1'b0, 1'b1);
      end
      idle(6);
      // Maximum luma and Cb gains push those channels past the rails and zero Cr gain holds Cr at 128, so no rounding is involved
      wr(ADDR_SCALE_LOW, 8'h0f);
      wr(ADDR_LUMA_SCALE, 8'hff);
      wr(ADDR_CB_SCALE, 8'hff);
      wr(ADDR_CR_SCALE, 8'h00);
      idle(4);
      p = {1'b1, 8'hc8, 8'hff, 8'($urandom)};
      px(p, p, {1'b1, 8'hff, 8'hff, 8'h80}, 1'b0, 1'b1);
      p = {1'b1, 8'h00, 8'h00, 8'($urandom)};
      px(p, p, {1'b1, 8'h00, 8'h00, 8'h80}, 1'b0, 1'b1);
      idle(6);
      $display("test scaling done");
      wr(ADDR_MODE_SEL, 8'h10);
      wr(ADDR_HD_PATTERN, 8'h04);
      wr(ADDR_PAT_SECOND, 8'h80);
      wr(ADDR_PAT_THIRD, 8'h80);
      for (int k = 0; k < 2; k++) begin
         wr(ADDR_PAT_FIRST, k ? 8'h10 : 8'heb);
         idle(4);
         repeat (2) begin
            p = {1'b1, 24'($urandom)};
            px(p, {1'b1, k ? 8'h10 : 8'heb, 8'h80, 8'h80}, p, 1'b1, 1'b0);
         end
         idle(6);
      end
      $display("test pattern done");
      wr(ADDR_HD_PATTERN, 8'h00);
      // Unity gains coded as 1.0 times 315; chroma kept at or above zero, so no rounding
      wr(ADDR_GY_HIGH, 8'h4e);
      wr(ADDR_GY_LOW, 8'h03);
      wr(ADDR_BU_HIGH, 8'h4e);
      wr(ADDR_RV_HIGH, 8'h4e);
      wr(ADDR_SHARED_LOW, 8'h0f);
      wr(ADDR_OUT_CTRL, 8'h28);
      idle(4);
      repeat (4) begin
         p = {1'b1, 8'($urandom), 1'b1, 7'($urandom), 1'b1, 7'($urandom)};
         px(p, p, p, 1'b1, 1'b0);
      end
      idle(6);
      $display("test manual matrix done");
      wr(ADDR_HD_IN_CTRL, 8'h06);
      wr(ADDR_OUT_CTRL, 8'h18);
      idle(4);
      @(negedge ref_clk);
      cmp({23'h0, sync_rgb, sync_prpb}, 25'h3);
      repeat (4) begin
         p = {1'b1, 24'($urandom)};
         px(p, p, p, 1'b1, 1'b0);
      end
      idle(6);
      $display("test passthrough done");
      results();
   end
endmodule : testbench
